// ==== pot_params.svh ====
// Shared constants of the potentiometer command link
`ifndef POT_PARAMS_SVH
`define POT_PARAMS_SVH

// Arbitrary device type value, not any real part's code
`define POT_DEV_TYPE_DEF 4'hA
`define POT_WORD_W       10
`define NV_RESET_VAL     10'h000

// Byte fields
`define ID_TYPE_RANGE    7:4
`define ID_ADDR_RANGE    3:1
`define ID_RW_BIT        0
`define INS_OP_RANGE     7:5
`define INS_SEL_RANGE    3:2
`define DATA_HI_RANGE    9:8
`define DATA_LO_MSB      7
`define DATA_LO_RANGE    `DATA_LO_MSB:0

// Opcodes with direction bit
`define OP_RD_WIPER       4'hC
`define OP_WR_WIPER       4'h5
`define OP_RD_STORED      4'hD
`define OP_WR_STORED      4'h6
`define OP_COPY_TO_WIPER  4'hE
`define OP_COPY_TO_STORED 4'h7

// Bit slots within a byte frame
`define LAST_BIT         4'h7
`define ACK_SLOT         4'h8

// Timing
`define NV_WRITE_US      10000
`define REF_CLK_MHZ      40
`define SCL_QTR_CYC      2

`endif

// ==== pot_pkg.sv ====
// Command type and opcode helpers shared by both link ends
`include "pot_params.svh"
package pot_pkg;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_RD_WIPER,
    CMD_WR_WIPER,
    CMD_RD_STORED,
    CMD_WR_STORED,
    CMD_COPY_TO_WIPER,
    CMD_COPY_TO_STORED
  } cmd_t;

  // Returns {direction, opcode}; direction 1 is read
  function automatic logic [3:0] cmd_code(cmd_t c);
    logic [3:0] r;
    r = `OP_RD_WIPER;
    unique case (c)
      CMD_WR_WIPER:      r = `OP_WR_WIPER;
      CMD_RD_STORED:     r = `OP_RD_STORED;
      CMD_WR_STORED:     r = `OP_WR_STORED;
      CMD_COPY_TO_WIPER:  r = `OP_COPY_TO_WIPER;
      CMD_COPY_TO_STORED: r = `OP_COPY_TO_STORED;
      default:           r = `OP_RD_WIPER;
    endcase
    return r;
  endfunction : cmd_code

  function automatic cmd_t cmd_decode(logic rw, logic [2:0] op);
    cmd_t c;
    c = CMD_NONE;
    case ({rw, op})
      `OP_RD_WIPER:      c = CMD_RD_WIPER;
      `OP_WR_WIPER:      c = CMD_WR_WIPER;
      `OP_RD_STORED:     c = CMD_RD_STORED;
      `OP_WR_STORED:     c = CMD_WR_STORED;
      `OP_COPY_TO_WIPER:  c = CMD_COPY_TO_WIPER;
      `OP_COPY_TO_STORED: c = CMD_COPY_TO_STORED;
      default:           c = CMD_NONE;
    endcase
    return c;
  endfunction : cmd_decode

endpackage : pot_pkg

// ==== pot_link_if.sv ====
// Two-wire link between the host end and the potentiometer end
interface pot_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Open-drain wire: low when any enabled driver pulls low
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport host_mp (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev_mp  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : pot_link_if

// ==== pot_register_command_unit.sv ====
// Device end: command decoder with wiper and stored-setting registers
`include "pot_params.svh"
module pot_register_command_unit #(
  parameter logic [3:0]  DEV_TYPE = `POT_DEV_TYPE_DEF,
  parameter int unsigned NV_CYC   = `NV_WRITE_US * `REF_CLK_MHZ
) (
  // Clock and reset
  input  wire logic                    REF_CLK_I,
  input  wire logic                    RST_I,
  // Serial link, clocked by its own scl
  pot_link_if.dev_mp                   LINK,
  // Address straps
  input  wire logic [2:0]              SLAVE_ADDR_PINS_I,
  // Status toward the analog side
  output logic      [`POT_WORD_W-1:0]  WIPER_POSITION_O,
  output logic                         NV_BUSY_O
);

  localparam int TW = $clog2(NV_CYC + 1);

  typedef enum logic [2:0] {
    L_IDLE,
    L_ID,
    L_INSTR,
    L_WR_HI,
    L_WR_LO,
    L_RD_HI,
    L_RD_LO
  } lstate_t;

  typedef struct packed {
    lstate_t                          st;
    logic [3:0]                       cnt;
    logic [7:0]                       sh;
    logic [7:0]                       tx;
    logic                             rw;
    pot_pkg::cmd_t                    cmd;
    logic [1:0]                       sel;
    logic [1:0]                       hi;
    logic [`POT_WORD_W-1:0]           rdval;
    logic [`POT_WORD_W-1:0]           wiper;
    logic [3:0][`POT_WORD_W-1:0]      stored;
    logic                             drive;
    logic                             start_seen;
    logic                             wiper_tog;
    logic                             nv_tog;
    logic [2:0]                       addr_s1;
    logic [2:0]                       addr_s2;
    logic                             busy_s1;
    logic                             busy_s2;
  } link_t;

  typedef struct packed {
    logic                             stop_s1;
    logic                             stop_s2;
    logic                             stop_seen;
    logic                             nv_s1;
    logic                             nv_s2;
    logic                             nv_seen;
    logic                             wt_s1;
    logic                             wt_s2;
    logic                             wt_seen;
    logic                             busy;
    logic [TW-1:0]                    timer;
    logic [`POT_WORD_W-1:0]           wiper_out;
  } core_t;

  link_t lr_r;
  link_t lr_nxt;
  core_t cr_r;
  core_t cr_nxt;
  logic  start_tog_r;
  logic  stop_tog_r;
  logic  sda_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Start and stop detection on data edges while scl is high

  // The toggle changes with scl high, three quarters of a period before the next rising
  // scl edge reads it, so the link domain sees it settled
  always_ff @(negedge LINK.sda or posedge RST_I) begin
    if (RST_I) begin
      start_tog_r <= 1'h0;
    end else if (LINK.scl) begin
      start_tog_r <= ~start_tog_r;
    end
  end

  // No scl edge follows a stop, so the core domain takes it over
  always_ff @(posedge LINK.sda or posedge RST_I) begin
    if (RST_I) begin
      stop_tog_r <= 1'h0;
    end else if (LINK.scl) begin
      stop_tog_r <= ~stop_tog_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: bit framing and command decode on rising scl

  always_comb begin
    logic [7:0]             b;
    logic                   ack;
    logic [`POT_WORD_W-1:0] val;
    logic [1:0]             bsel;
    pot_pkg::cmd_t          c;
    b    = {lr_r.sh[6:0], LINK.sda};
    ack  = 1'h0;
    val  = {lr_r.hi, b};
    bsel = b[`INS_SEL_RANGE];
    c    = pot_pkg::cmd_decode(lr_r.rw, b[`INS_OP_RANGE]);
    lr_nxt         = lr_r;
    lr_nxt.addr_s1 = SLAVE_ADDR_PINS_I;
    lr_nxt.addr_s2 = lr_r.addr_s1;
    lr_nxt.busy_s1 = cr_r.busy;
    lr_nxt.busy_s2 = lr_r.busy_s1;
    lr_nxt.drive   = 1'h0;
    if (start_tog_r != lr_r.start_seen) begin
      lr_nxt.start_seen = start_tog_r;
      lr_nxt.st         = L_ID;
      lr_nxt.cnt        = 4'h1;
      lr_nxt.sh         = b;
    end else if (lr_r.cnt == `ACK_SLOT) begin
      lr_nxt.cnt = 4'h0;
      if (lr_r.st == L_RD_HI) begin
        // Six don't-care bits go out as zero
        lr_nxt.tx    = {6'h00, lr_r.rdval[`DATA_HI_RANGE]};
        lr_nxt.drive = 1'h1;
      end else if (lr_r.st == L_RD_LO && LINK.sda) begin
        lr_nxt.st = L_IDLE;
      end else if (lr_r.st == L_RD_LO) begin
        lr_nxt.tx    = lr_r.rdval[`DATA_LO_RANGE];
        lr_nxt.drive = ~lr_r.rdval[`DATA_LO_MSB];
      end
    end else if (lr_r.st != L_IDLE) begin
      lr_nxt.sh  = b;
      lr_nxt.cnt = lr_r.cnt + 4'h1;
      if (lr_r.st == L_RD_HI || lr_r.st == L_RD_LO) begin
        lr_nxt.tx    = lr_r.tx << 1;
        lr_nxt.drive = (lr_r.cnt != `LAST_BIT) && !lr_r.tx[6];
        if (lr_r.cnt == `LAST_BIT) begin
          lr_nxt.st = (lr_r.st == L_RD_HI) ? L_RD_LO : L_IDLE;
        end
      end else if (lr_r.cnt == `LAST_BIT) begin
        unique case (lr_r.st)
          L_ID: begin
            ack = (b[`ID_TYPE_RANGE] == DEV_TYPE)
               && (b[`ID_ADDR_RANGE] == lr_r.addr_s2)
               && !lr_r.busy_s2;
            lr_nxt.rw = b[`ID_RW_BIT];
            lr_nxt.st = L_INSTR;
          end
          L_INSTR: begin
            ack          = (c != pot_pkg::CMD_NONE);
            lr_nxt.cmd   = c;
            lr_nxt.sel   = bsel;
            lr_nxt.rdval = (c == pot_pkg::CMD_RD_WIPER) ? lr_r.wiper : lr_r.stored[bsel];
            unique case (c)
              pot_pkg::CMD_RD_WIPER, pot_pkg::CMD_RD_STORED: begin
                lr_nxt.st = L_RD_HI;
              end
              pot_pkg::CMD_WR_WIPER, pot_pkg::CMD_WR_STORED: begin
                lr_nxt.st = L_WR_HI;
              end
              pot_pkg::CMD_COPY_TO_WIPER: begin
                lr_nxt.wiper     = lr_r.stored[bsel];
                lr_nxt.wiper_tog = ~lr_r.wiper_tog;
                lr_nxt.st        = L_IDLE;
              end
              pot_pkg::CMD_COPY_TO_STORED: begin
                lr_nxt.stored[bsel] = lr_r.wiper;
                lr_nxt.nv_tog       = ~lr_r.nv_tog;
                lr_nxt.st           = L_IDLE;
              end
              default: lr_nxt.st = L_IDLE;
            endcase
          end
          L_WR_HI: begin
            ack       = 1'h1;
            lr_nxt.hi = b[1:0];
            lr_nxt.st = L_WR_LO;
          end
          L_WR_LO: begin
            ack       = 1'h1;
            lr_nxt.st = L_IDLE;
            if (lr_r.cmd == pot_pkg::CMD_WR_WIPER) begin
              lr_nxt.wiper     = val;
              lr_nxt.wiper_tog = ~lr_r.wiper_tog;
            end else begin
              // Any 10-bit value is kept, wiper use or not
              lr_nxt.stored[lr_r.sel] = val;
              lr_nxt.nv_tog           = ~lr_r.nv_tog;
            end
          end
          default: lr_nxt.st = L_IDLE;
        endcase
        lr_nxt.drive = ack;
        if (!ack) begin
          lr_nxt.st = L_IDLE;
        end
      end
    end
  end

  always_ff @(posedge LINK.scl or posedge RST_I) begin
    if (RST_I) begin
      lr_r        <= '0;
      lr_r.stored <= {4{`NV_RESET_VAL}};
      lr_r.wiper  <= `NV_RESET_VAL;
    end else begin
      lr_r <= lr_nxt;
    end
  end

  // Drive changes only while scl is low
  always_ff @(negedge LINK.scl or posedge RST_I) begin
    if (RST_I) begin
      sda_oe_r <= 1'h0;
    end else begin
      sda_oe_r <= lr_r.drive;
    end
  end

  assign LINK.dev_sda_o  = 1'h0;
  assign LINK.dev_sda_oe = sda_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: wiper output and nonvolatile write timing

  // The wiper word is sampled only after its toggle has crossed; this holds
  // while an scl period spans more than three reference clocks
  always_comb begin
    cr_nxt         = cr_r;
    cr_nxt.stop_s1 = stop_tog_r;
    cr_nxt.stop_s2 = cr_r.stop_s1;
    cr_nxt.nv_s1   = lr_r.nv_tog;
    cr_nxt.nv_s2   = cr_r.nv_s1;
    cr_nxt.wt_s1   = lr_r.wiper_tog;
    cr_nxt.wt_s2   = cr_r.wt_s1;
    if (cr_r.wt_s2 != cr_r.wt_seen) begin
      cr_nxt.wt_seen   = cr_r.wt_s2;
      cr_nxt.wiper_out = lr_r.wiper;
    end
    if (cr_r.busy && cr_r.timer == '0) begin
      cr_nxt.busy = 1'h0;
    end else if (cr_r.busy) begin
      cr_nxt.timer = cr_r.timer - TW'(1);
    end
    if (cr_r.stop_s2 != cr_r.stop_seen) begin
      cr_nxt.stop_seen = cr_r.stop_s2;
      if (cr_r.nv_s2 != cr_r.nv_seen) begin
        cr_nxt.nv_seen = cr_r.nv_s2;
        cr_nxt.busy    = 1'h1;
        cr_nxt.timer   = TW'(NV_CYC - 1);
      end
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cr_r           <= '0;
      cr_r.wiper_out <= `NV_RESET_VAL;
    end else begin
      cr_r <= cr_nxt;
    end
  end

  assign WIPER_POSITION_O = cr_r.wiper_out;
  assign NV_BUSY_O        = cr_r.busy;

endmodule : pot_register_command_unit

// ==== pot_bus_host.sv ====
// Host end: frames user commands onto the two-wire link and polls nonvolatile writes
`include "pot_params.svh"
module pot_bus_host #(
  parameter logic [3:0]  DEV_TYPE = `POT_DEV_TYPE_DEF,
  parameter int unsigned QTR      = `SCL_QTR_CYC
) (
  // Clock and reset
  input  wire logic                    REF_CLK_I,
  input  wire logic                    RST_I,
  // Command request
  input  wire logic                    CMD_VALID_I,
  output logic                         CMD_READY_O,
  input  wire pot_pkg::cmd_t           CMD_KIND_I,
  input  wire logic [2:0]              CMD_ADDR_I,
  input  wire logic [1:0]              CMD_SEL_I,
  input  wire logic [`POT_WORD_W-1:0]  CMD_DATA_I,
  // Answer
  output logic                         RSP_VALID_O,
  output logic                         RSP_ACK_O,
  output logic      [`POT_WORD_W-1:0]  RSP_DATA_O,
  // Serial link
  pot_link_if.host_mp                  LINK
);

  localparam int DW = $clog2(QTR + 1);

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} hstate_t;

  typedef struct packed {
    hstate_t                st;
    logic [DW-1:0]          div;
    logic [1:0]             q;
    logic [3:0]             bitn;
    logic [1:0]             idx;
    pot_pkg::cmd_t          cmd;
    logic [2:0]             addr;
    logic [1:0]             sel;
    logic [`POT_WORD_W-1:0] data;
    logic [7:0]             rx;
    logic                   nack;
    logic                   ok;
    logic                   poll;
    logic                   scl;
    logic                   drv;
    logic                   sda_s1;
    logic                   sda_s2;
    logic                   rsp_valid;
    logic                   rsp_ack;
    logic [`POT_WORD_W-1:0] rd;
  } host_t;

  host_t hr_r;
  host_t hr_nxt;

  always_comb begin
    logic [3:0] code;
    logic       rwb;
    logic       nv;
    logic       send;
    logic [1:0] last;
    logic [7:0] cur;
    cur  = 8'h00;
    code = pot_pkg::cmd_code(hr_r.cmd);
    rwb  = code[3] & ~hr_r.poll;
    nv   = (hr_r.cmd == pot_pkg::CMD_WR_STORED) || (hr_r.cmd == pot_pkg::CMD_COPY_TO_STORED);
    send = !(rwb && hr_r.idx[1]);
    last = hr_r.poll ? 2'h0 :
           (hr_r.cmd == pot_pkg::CMD_COPY_TO_WIPER || hr_r.cmd == pot_pkg::CMD_COPY_TO_STORED) ? 2'h1 :
           2'h3;
    unique case (hr_r.idx)
      2'h0:    cur = {DEV_TYPE, hr_r.addr, rwb};
      2'h1:    cur = {code[2:0], 1'h0, hr_r.sel, 2'h0};
      2'h2:    cur = {6'h00, hr_r.data[`DATA_HI_RANGE]};
      default: cur = hr_r.data[`DATA_LO_RANGE];
    endcase
    hr_nxt           = hr_r;
    hr_nxt.sda_s1    = LINK.sda;
    hr_nxt.sda_s2    = hr_r.sda_s1;
    hr_nxt.rsp_valid = 1'h0;
    if (hr_r.st == H_IDLE) begin
      if (CMD_VALID_I) begin
        hr_nxt.cmd  = CMD_KIND_I;
        hr_nxt.addr = CMD_ADDR_I;
        hr_nxt.sel  = CMD_SEL_I;
        hr_nxt.data = CMD_DATA_I;
        hr_nxt.poll = 1'h0;
        hr_nxt.st   = H_START;
        hr_nxt.q    = 2'h0;
        hr_nxt.div  = '0;
      end
    end else if (hr_r.div != DW'(QTR - 1)) begin
      hr_nxt.div = hr_r.div + DW'(1);
    end else begin
      hr_nxt.div = '0;
      hr_nxt.q   = hr_r.q + 2'h1;
      unique case (hr_r.st)
        H_START: begin
          unique case (hr_r.q)
            2'h0: begin
              hr_nxt.scl = 1'h0;
              hr_nxt.drv = 1'h0;
            end
            2'h1: hr_nxt.scl = 1'h1;
            2'h2: hr_nxt.drv = 1'h1;
            default: begin
              hr_nxt.scl  = 1'h0;
              hr_nxt.st   = H_BIT;
              hr_nxt.bitn = 4'h0;
              hr_nxt.idx  = 2'h0;
              hr_nxt.ok   = 1'h1;
            end
          endcase
        end
        H_BIT: begin
          unique case (hr_r.q)
            2'h0: hr_nxt.drv = (hr_r.bitn == `ACK_SLOT) ? !send : send && !cur[3'h7 - hr_r.bitn[2:0]];
            2'h1: hr_nxt.scl = 1'h1;
            2'h2: begin
              if (hr_r.bitn == `ACK_SLOT) hr_nxt.nack = hr_r.sda_s2;
              else hr_nxt.rx = {hr_r.rx[6:0], hr_r.sda_s2};
            end
            default: begin
              hr_nxt.scl  = 1'h0;
              hr_nxt.bitn = hr_r.bitn + 4'h1;
              if (hr_r.bitn == `ACK_SLOT) begin
                hr_nxt.bitn = 4'h0;
                hr_nxt.idx  = hr_r.idx + 2'h1;
                if (!send && hr_r.idx == 2'h2) hr_nxt.rd[`DATA_HI_RANGE] = hr_r.rx[1:0];
                if (!send && hr_r.idx == 2'h3) hr_nxt.rd[`DATA_LO_RANGE] = hr_r.rx;
                if ((send && hr_r.nack) || hr_r.idx == last) begin
                  hr_nxt.ok = !(send && hr_r.nack);
                  hr_nxt.st = H_STOP;
                end
              end
            end
          endcase
        end
        H_STOP: begin
          unique case (hr_r.q)
            2'h0: begin
              hr_nxt.scl = 1'h0;
              hr_nxt.drv = 1'h1;
            end
            2'h1: hr_nxt.scl = 1'h1;
            2'h2: hr_nxt.drv = 1'h0;
            default: begin
              if ((!hr_r.poll && nv && hr_r.ok) || (hr_r.poll && !hr_r.ok)) begin
                hr_nxt.poll = 1'h1;
                hr_nxt.st   = H_START;
              end else begin
                hr_nxt.rsp_valid = 1'h1;
                hr_nxt.rsp_ack   = hr_r.poll | hr_r.ok;
                hr_nxt.st        = H_IDLE;
              end
            end
          endcase
        end
        default: hr_nxt.st = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      hr_r     <= '0;
      hr_r.scl <= 1'h1;
    end else begin
      hr_r <= hr_nxt;
    end
  end

  assign CMD_READY_O      = (hr_r.st == H_IDLE);
  assign RSP_VALID_O      = hr_r.rsp_valid;
  assign RSP_ACK_O        = hr_r.rsp_ack;
  assign RSP_DATA_O       = hr_r.rd;
  assign LINK.scl         = hr_r.scl;
  assign LINK.host_sda_o  = 1'h0;
  assign LINK.host_sda_oe = hr_r.drv;

endmodule : pot_bus_host

// ==== pot_link_properties.sv ====
// Timing and ownership checks on the two-wire link between the two ends
module pot_link_properties #(
  parameter int unsigned QTR = 2
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // Link wires
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  typedef struct packed {
    logic [15:0] hi_len;
    logic [15:0] lo_len;
  } run_len_t;

  run_len_t len_r;
  run_len_t len_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Saturating run lengths, so a long idle never wraps to a short phase
  always_comb begin
    len_nxt = len_r;
    len_nxt.hi_len = !scl ? 16'h0000 : (&len_r.hi_len ? len_r.hi_len : len_r.hi_len + 16'h0001);
    len_nxt.lo_len = scl ? 16'h0000 : (&len_r.lo_len ? len_r.lo_len : len_r.lo_len + 16'h0001);
  end

  // Clock idles high in reset, so the high run starts saturated
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      len_r <= {16'hffff, 16'h0000};
    end else begin
      len_r <= len_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);

  sequence seq_stop;
    scl && $rose(sda);
  endsequence

  sequence seq_start;
    scl && $fell(sda);
  endsequence

  sequence seq_bit_clock;
    ##[1:16] $rose(scl) ##1 scl;
  endsequence

  a_reset_idle: assert property ($fell(RST_I) |-> scl && !host_sda_oe && !dev_sda_oe)
    else $error("link not idle after reset");
  a_start_by_host: assert property (seq_start |-> host_sda_oe && $past(scl))
    else $error("start not made by host");
  a_stop_by_host: assert property (seq_stop |-> $past(host_sda_oe) && !host_sda_oe)
    else $error("stop not made by host");
  a_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device moved data while clock high");
  a_dev_bit_hold: assert property ($rose(dev_sda_oe) |-> dev_sda_oe throughout seq_bit_clock)
    else $error("device bit not held through clock high");
  a_quiet_after_stop: assert property (seq_stop |=> !dev_sda_oe [*8])
    else $error("device drove link after stop");
  a_scl_high_len: assert property ($fell(scl) |-> len_r.hi_len >= 2 * QTR)
    else $error("clock high phase too short");
  a_scl_low_len: assert property ($rose(scl) |-> len_r.lo_len >= QTR)
    else $error("clock low phase too short");
endmodule : pot_link_properties

// ==== pot_register_command_unit_test.sv ====
// Self-checking bench: host end and device end joined over the link
`include "pot_params.svh"
module pot_register_command_unit_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned NV = 200;

  logic                   clk;
  logic                   rst;
  logic                   cmd_valid;
  pot_pkg::cmd_t          cmd_kind;
  logic [2:0]             cmd_addr;
  logic [1:0]             cmd_sel;
  logic [`POT_WORD_W-1:0] cmd_data;
  logic [2:0]             pins;
  logic                   cmd_ready;
  logic                   rsp_valid;
  logic                   rsp_ack;
  logic [`POT_WORD_W-1:0] rsp_data;
  logic [`POT_WORD_W-1:0] wiper_pos;
  logic                   nv_busy;
  logic [`POT_WORD_W-1:0] wiper_m;
  logic [`POT_WORD_W-1:0] stored_m [4];
  int                     busy_len;
  int                     failures;
  int                     compares;

  pot_link_if link ();

  pot_register_command_unit #(.NV_CYC(NV)) i_pot_register_command_unit (.REF_CLK_I(clk), .RST_I(rst),
    .LINK(link.dev_mp), .SLAVE_ADDR_PINS_I(pins), .WIPER_POSITION_O(wiper_pos), .NV_BUSY_O(nv_busy));

  pot_bus_host i_pot_bus_host (.REF_CLK_I(clk), .RST_I(rst), .CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready),
    .CMD_KIND_I(cmd_kind), .CMD_ADDR_I(cmd_addr), .CMD_SEL_I(cmd_sel), .CMD_DATA_I(cmd_data),
    .RSP_VALID_O(rsp_valid), .RSP_ACK_O(rsp_ack), .RSP_DATA_O(rsp_data), .LINK(link.host_mp));

  pot_link_properties #(.QTR(`SCL_QTR_CYC)) i_pot_link_properties (.REF_CLK_I(clk), .RST_I(rst),
    .scl(link.scl), .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input string what, input logic [9:0] exp, input logic [9:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic report_and_stop();
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Request held from one falling edge past the taking rising edge
  task automatic do_cmd(input pot_pkg::cmd_t k, input logic [2:0] a, input logic [1:0] s, input logic [9:0] d);
    int n;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_addr = a;
    cmd_sel = s;
    cmd_data = d;
    @(negedge clk);
    cmd_valid = 1'b0;
    busy_len = 0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
      if (nv_busy === 1'b1) busy_len++;
    end
    if (n >= 20000) failures++;
  endtask : do_cmd

  // Read value the register model predicts, taken before the command lands
  function automatic logic [9:0] exp_read(input pot_pkg::cmd_t k, input logic [1:0] s);
    return (k == pot_pkg::CMD_RD_WIPER) ? wiper_m : stored_m[s];
  endfunction : exp_read

  // Runs one accepted command and checks it against the register model
  task automatic run(input pot_pkg::cmd_t k, input logic [1:0] s, input logic [9:0] d);
    logic [9:0] exp;
    do_cmd(k, pins, s, d);
    exp = exp_read(k, s);
    case (k)
      pot_pkg::CMD_WR_WIPER: wiper_m = d;
      pot_pkg::CMD_WR_STORED: stored_m[s] = d;
      pot_pkg::CMD_COPY_TO_WIPER: wiper_m = stored_m[s];
      pot_pkg::CMD_COPY_TO_STORED: stored_m[s] = wiper_m;
      default: ;
    endcase
    chk_bit("ack", 1'b1, rsp_ack);
    chk_word("wiper out", wiper_m, wiper_pos);
    if (k inside {pot_pkg::CMD_RD_WIPER, pot_pkg::CMD_RD_STORED}) chk_word("read", exp, rsp_data);
    if (k inside {pot_pkg::CMD_WR_STORED, pot_pkg::CMD_COPY_TO_STORED}) begin
      chk_bit("nv window", 1'b1, busy_len >= NV && busy_len <= NV + 4);
      chk_bit("busy at answer", 1'b0, nv_busy);
    end
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  initial begin
    failures = 0;
    compares = 0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_kind = pot_pkg::CMD_RD_WIPER;
    cmd_addr = 3'h0;
    cmd_sel = 2'h0;
    cmd_data = 10'h000;
    void'($urandom(32'hc2c7_d5bc));
    pins = 3'($urandom);
    wiper_m = 10'h000;
    stored_m = '{default: 10'h000};
    repeat (6) @(negedge clk);
    rst = 1'b0;
    run(pot_pkg::CMD_RD_WIPER, 2'h0, 10'h000);
    run(pot_pkg::CMD_WR_WIPER, 2'h0, 10'h3ff);
    run(pot_pkg::CMD_RD_WIPER, 2'h0, 10'h000);
    run(pot_pkg::CMD_WR_WIPER, 2'h0, 10'h000);
    for (int i = 0; i < 4; i++) begin
      run(pot_pkg::CMD_WR_STORED, 2'(i), 10'($urandom));
      run(pot_pkg::CMD_COPY_TO_WIPER, 2'(i), 10'h000);
      run(pot_pkg::CMD_WR_WIPER, 2'h0, 10'($urandom));
      run(pot_pkg::CMD_COPY_TO_STORED, 2'(3 - i), 10'h000);
      run(pot_pkg::CMD_RD_WIPER, 2'h0, 10'h000);
    end
    for (int i = 0; i < 4; i++) run(pot_pkg::CMD_RD_STORED, 2'(i), 10'h000);
    do_cmd(pot_pkg::CMD_WR_WIPER, pins ^ 3'h1, 2'h0, 10'h155);
    chk_bit("foreign address ack", 1'b0, rsp_ack);
    chk_word("wiper kept", wiper_m, wiper_pos);
    run(pot_pkg::CMD_RD_STORED, 2'h2, 10'h000);
    report_and_stop();
  end
endmodule : pot_register_command_unit_test
